// ### acfc_pkg.sv
// Summary of operation
// - Four calibration modes started by writing operating mode.
// - Calibration start raises ready pin and status bit.
// - Calibration end: store coefficient, ready low, idle.
// - Result minus offset, times full-scale, into data.
// - Internal cals route references; system cals need host voltage.
// - Chop off: zero-scale calibration takes one settling time.
// - Chop on: internal zero two periods, system one settle.
// - Internal full-scale: one settle at gain 1, else two.
// - System full-scale calibration takes one settling time.
// - Coefficients readable always, writable only idle or power-down.
// - Filter order, chop and zero latency set timing.
// - Power-up default: fourth-order filter, chop off.
// - Output period is 1024 times filter word clocks.
// - Filter word ranges from 1 to 1023.
// - Fourth-order settling time is four output periods.
// - Channel change resets filter, first result after settling.
// - Input step does not interrupt conversion rate.
// - Temperature select bit routes sensor to converter.
// - Bipolar temperature code 0x800000 at zero kelvin.
// - Zero latency bit 11: every conversion takes settling time.
// - Third-order select bit replaces fourth-order filter.
package acfc_pkg;

  localparam int ADDR_W = 8;
  localparam int CNT_W  = 21;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] CONF_ADDR = 8'h04;
  localparam logic [7:0] STAT_ADDR = 8'h08;
  localparam logic [7:0] DATA_ADDR = 8'h0c;
  localparam logic [7:0] OFFC_ADDR = 8'h10;
  localparam logic [7:0] FSC_ADDR  = 8'h14;

  localparam int MODE_FW_LSB    = 0;
  localparam int MODE_ZL_BIT    = 11;
  localparam int MODE_THIRD_ORDER_FILTER_SELECT_BIT = 12;
  localparam int MODE_CHOP_BIT  = 13;
  localparam int MODE_OP_LSB    = 21;
  localparam int CONF_GAIN_LSB  = 0;
  localparam int CONF_TEMP_BIT  = 3;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NRDY_BIT  = 7;

  localparam logic [9:0]  FW_RESET   = 10'h060;
  localparam logic [9:0]  FW_MIN     = 10'h001;
  localparam logic [23:0] COEF_RESET = 24'h800000;
  localparam logic [2:0]  GAIN_ONE   = 3'h0;

  // ----------------------------------------------------------------
  // Timing in output periods
  // ----------------------------------------------------------------
  localparam logic [3:0] SETTLE_SINC4 = 4'h4;
  localparam logic [3:0] SETTLE_THIRD_ORDER_FILTER_SELECT = 4'h3;
  localparam logic [3:0] SETTLE_CHOP  = 4'h2;
  localparam logic [3:0] PERIODS_ONE  = 4'h1;

  // ----------------------------------------------------------------
  // Scaling and sensor
  // ----------------------------------------------------------------
  localparam int                 UNITY_SHIFT  = 23;
  localparam logic [23:0]        CODE_MID     = 24'h800000;
  localparam logic [23:0]        CODE_MAX     = 24'hffffff;
  localparam logic [23:0]        CODE_MIN     = 24'h000000;
  localparam logic signed [49:0] POS_LIM      = 50'sh00000007fffff;
  localparam logic signed [49:0] NEG_LIM      = 50'sh3ffffff800000;
  localparam logic [23:0]        TEMP_ZERO_K  = 24'h800000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    OP_CONT     = 3'h0,
    OP_SINGLE   = 3'h1,
    OP_IDLE     = 3'h2,
    OP_PDOWN    = 3'h3,
    OP_ZERO_INT = 3'h4,
    OP_FULL_INT = 3'h5,
    OP_ZERO_SYS = 3'h6,
    OP_FULL_SYS = 3'h7
  } acfc_op_t;

  typedef enum logic [1:0] {
    SEL_EXT  = 2'h0,
    SEL_TEMP = 2'h1,
    SEL_ZERO = 2'h2,
    SEL_FULL = 2'h3
  } acfc_sel_t;

  typedef enum logic [1:0] {ENG_IDLE, ENG_CONV, ENG_CAL} acfc_eng_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } acfc_axi_in_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } acfc_axi_out_t;

  typedef struct packed {
    acfc_op_t          op;
    logic [9:0]        filterWord;
    logic              zeroLatency;
    logic              thirdOrder;
    logic              chop;
    logic [2:0]        gain;
    logic              tempSel;
    logic [23:0]       offsetCoef;
    logic [23:0]       fullCoef;
    logic [23:0]       data;
    logic              notReady;
    acfc_eng_t         eng;
    logic [CNT_W-1:0]  periodCnt;
    logic [3:0]        periodsLeft;
    logic              modReset;
    logic              awSeen;
    logic [ADDR_W-1:0] awAddr;
    logic              wSeen;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } acfc_state_t;

endpackage

// ### acfc_control.sv
`timescale 1ns/1ps
module acfc_control
  import acfc_pkg::*;
#(
  parameter int PERIOD_MULT = 1024
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // Register bus
  input  wire acfc_axi_in_t  axiIn,
  output acfc_axi_out_t      axiOut,
  // Converter side
  input  wire logic [23:0]   rawSample,
  output acfc_sel_t          inputSel,
  output logic               modReset,
  // Serial pin
  input  wire logic          csN,
  output logic               doutRdyOut,
  output logic               doutRdyOeN
);

  acfc_state_t      r;
  acfc_state_t      next_r;
  logic [CNT_W-1:0] periodLen;
  logic             lastCycle;
  logic             convDone;
  logic             calDone;
  logic [3:0]       settleP;
  logic [3:0]       calP;
  logic [31:0]      wMask;
  logic [31:0]      modeWord;
  logic [31:0]      confWord;
  logic [31:0]      newWord;
  logic [31:0]      readWord;
  logic             readHit;
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] shifted;
  logic [23:0]      scaled;
  logic             writeGo;

  // ----------------------------------------------------------------
  // Timing helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] settle_of(input logic third_order_filter_select,
                                           input logic chopOn);
    if (chopOn) begin
      return SETTLE_CHOP;
    end
    return third_order_filter_select ? SETTLE_THIRD_ORDER_FILTER_SELECT : SETTLE_SINC4;
  endfunction

  function automatic logic [3:0] cal_of(input acfc_op_t op,
                                        input logic [3:0] st,
                                        input logic [2:0] g);
    if (op == OP_FULL_INT && g != GAIN_ONE) begin
      return 4'(st << 1);
    end
    return st;
  endfunction

  for (genvar i = 0; i < 4; i++) begin : g_mask
    assign wMask[8*i +: 8] = {8{r.wStrb[i]}};
  end

  assign periodLen = CNT_W'(PERIOD_MULT) * CNT_W'(r.filterWord);
  assign lastCycle = (r.periodCnt == periodLen - CNT_W'(1));
  assign convDone  = r.eng == ENG_CONV && lastCycle
                     && r.periodsLeft == PERIODS_ONE;
  assign calDone   = r.eng == ENG_CAL && lastCycle
                     && r.periodsLeft == PERIODS_ONE;
  assign settleP   = settle_of(r.thirdOrder, r.chop);
  assign writeGo   = r.awSeen && r.wSeen && !r.bvalid;

  // ----------------------------------------------------------------
  // Calibration scaling
  // ----------------------------------------------------------------
  assign diff    = $signed({1'b0, rawSample}) - $signed({1'b0, r.offsetCoef});
  assign prod    = 50'(diff * $signed({1'b0, r.fullCoef}));
  assign shifted = prod >>> UNITY_SHIFT;
  always_comb begin
    if (shifted > POS_LIM) begin
      scaled = CODE_MAX;
    end else if (shifted < NEG_LIM) begin
      scaled = CODE_MIN;
    end else begin
      scaled = shifted[23:0] + CODE_MID;
    end
  end

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  always_comb begin
    modeWord = '0;
    modeWord[MODE_FW_LSB +: 10] = r.filterWord;
    modeWord[MODE_ZL_BIT]       = r.zeroLatency;
    modeWord[MODE_THIRD_ORDER_FILTER_SELECT_BIT]    = r.thirdOrder;
    modeWord[MODE_CHOP_BIT]     = r.chop;
    modeWord[MODE_OP_LSB +: 3]  = r.op;
    confWord = '0;
    confWord[CONF_GAIN_LSB +: 3] = r.gain;
    confWord[CONF_TEMP_BIT]      = r.tempSel;
    readHit  = 1'b1;
    readWord = '0;
    unique case (axiIn.araddr)
      MODE_ADDR: readWord = modeWord;
      CONF_ADDR: readWord = confWord;
      STAT_ADDR: begin
        readWord[STAT_NRDY_BIT] = r.notReady;
        readWord[STAT_BUSY_BIT] = r.eng == ENG_CAL;
      end
      DATA_ADDR: readWord[23:0] = r.data;
      OFFC_ADDR: readWord[23:0] = r.offsetCoef;
      FSC_ADDR:  readWord[23:0] = r.fullCoef;
      default:   readHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.modReset = 1'b0;
    newWord         = '0;
    calP            = '0;
    // Period timing runs on through input steps
    if (r.eng != ENG_IDLE) begin
      if (lastCycle) begin
        next_r.periodCnt   = '0;
        next_r.periodsLeft = r.periodsLeft - PERIODS_ONE;
      end else begin
        next_r.periodCnt = r.periodCnt + CNT_W'(1);
      end
    end
    if (convDone) begin
      next_r.data        = scaled;
      next_r.notReady    = 1'b0;
      next_r.periodsLeft = r.zeroLatency ? settleP : PERIODS_ONE;
      if (r.op == OP_SINGLE) begin
        next_r.op  = OP_IDLE;
        next_r.eng = ENG_IDLE;
      end
    end
    if (calDone) begin
      if (r.op == OP_ZERO_INT || r.op == OP_ZERO_SYS) begin
        next_r.offsetCoef = rawSample;
      end else begin
        next_r.fullCoef = 24'(rawSample - r.offsetCoef);
      end
      next_r.notReady = 1'b0;
      next_r.op       = OP_IDLE;
      next_r.eng      = ENG_IDLE;
    end
    // Read channel; a data read marks the result consumed
    if (axiIn.arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rdata  = readWord;
      next_r.rresp  = readHit ? RESP_OKAY : RESP_SLVERR;
      if (axiIn.araddr == DATA_ADDR && !convDone && !calDone) begin
        next_r.notReady = 1'b1;
      end
    end
    if (r.rvalid && axiIn.rready) begin
      next_r.rvalid = 1'b0;
    end
    // Write address and data, taken in either order
    if (axiIn.awvalid && !r.awSeen && !r.bvalid) begin
      next_r.awSeen = 1'b1;
      next_r.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && !r.wSeen && !r.bvalid) begin
      next_r.wSeen = 1'b1;
      next_r.wData = axiIn.wdata;
      next_r.wStrb = axiIn.wstrb;
    end
    if (r.bvalid && axiIn.bready) begin
      next_r.bvalid = 1'b0;
    end
    if (writeGo) begin
      next_r.awSeen = 1'b0;
      next_r.wSeen  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = RESP_OKAY;
      unique case (r.awAddr)
        MODE_ADDR: begin
          newWord = (modeWord & ~wMask) | (r.wData & wMask);
          next_r.filterWord  = newWord[MODE_FW_LSB +: 10];
          if (newWord[MODE_FW_LSB +: 10] == '0) begin
            next_r.filterWord = FW_MIN;
          end
          next_r.zeroLatency = newWord[MODE_ZL_BIT];
          next_r.thirdOrder  = newWord[MODE_THIRD_ORDER_FILTER_SELECT_BIT];
          next_r.chop        = newWord[MODE_CHOP_BIT];
          next_r.op          = acfc_op_t'(newWord[MODE_OP_LSB +: 3]);
          next_r.periodCnt   = '0;
          next_r.modReset    = 1'b1;
          calP = cal_of(acfc_op_t'(newWord[MODE_OP_LSB +: 3]),
                        settle_of(newWord[MODE_THIRD_ORDER_FILTER_SELECT_BIT],
                                  newWord[MODE_CHOP_BIT]), r.gain);
          unique case (acfc_op_t'(newWord[MODE_OP_LSB +: 3]))
            OP_ZERO_INT, OP_FULL_INT, OP_ZERO_SYS, OP_FULL_SYS: begin
              next_r.eng         = ENG_CAL;
              next_r.notReady    = 1'b1;
              next_r.periodsLeft = calP;
            end
            OP_CONT, OP_SINGLE: begin
              next_r.eng         = ENG_CONV;
              next_r.notReady    = 1'b1;
              next_r.periodsLeft = calP;
            end
            OP_IDLE, OP_PDOWN: begin
              next_r.eng = ENG_IDLE;
            end
          endcase
        end
        CONF_ADDR: begin
          newWord = (confWord & ~wMask) | (r.wData & wMask);
          next_r.gain    = newWord[CONF_GAIN_LSB +: 3];
          next_r.tempSel = newWord[CONF_TEMP_BIT];
          // Channel change restarts the filter
          if (newWord[CONF_TEMP_BIT] != r.tempSel
              && r.eng == ENG_CONV) begin
            next_r.periodCnt   = '0;
            next_r.periodsLeft = settleP;
            next_r.modReset    = 1'b1;
            next_r.notReady    = 1'b1;
          end
        end
        OFFC_ADDR: begin
          if (r.op == OP_IDLE || r.op == OP_PDOWN) begin
            newWord = ({8'h00, r.offsetCoef} & ~wMask) | (r.wData & wMask);
            next_r.offsetCoef = newWord[23:0];
          end
        end
        FSC_ADDR: begin
          if (r.op == OP_IDLE || r.op == OP_PDOWN) begin
            newWord = ({8'h00, r.fullCoef} & ~wMask) | (r.wData & wMask);
            next_r.fullCoef = newWord[23:0];
          end
        end
        STAT_ADDR, DATA_ADDR: begin
          next_r.bresp = RESP_OKAY;
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r             <= '0;
      r.op          <= OP_IDLE;
      r.filterWord  <= FW_RESET;
      r.thirdOrder  <= 1'b0;
      r.chop        <= 1'b0;
      r.offsetCoef  <= COEF_RESET;
      r.fullCoef    <= COEF_RESET;
      r.notReady    <= 1'b1;
      r.eng         <= ENG_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (r.eng == ENG_CAL && r.op == OP_ZERO_INT) begin
      inputSel = SEL_ZERO;
    end else if (r.eng == ENG_CAL && r.op == OP_FULL_INT) begin
      inputSel = SEL_FULL;
    end else if (r.tempSel) begin
      inputSel = SEL_TEMP;
    end else begin
      inputSel = SEL_EXT;
    end
  end

  assign modReset       = r.modReset;
  assign doutRdyOut     = csN ? 1'b1 : r.notReady;
  assign doutRdyOeN     = csN;
  assign axiOut.awready = !r.awSeen && !r.bvalid;
  assign axiOut.wready  = !r.wSeen && !r.bvalid;
  assign axiOut.bvalid  = r.bvalid;
  assign axiOut.bresp   = r.bresp;
  assign axiOut.arready = !r.rvalid;
  assign axiOut.rvalid  = r.rvalid;
  assign axiOut.rdata   = r.rdata;
  assign axiOut.rresp   = r.rresp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_cal_start_busy: assert property (
    writeGo && r.awAddr == MODE_ADDR && next_r.eng == ENG_CAL
    |=> r.notReady && r.eng == ENG_CAL && doutRdyOut)
    else $error("calibration start did not raise ready flag");

  a_cal_end_idle: assert property (
    calDone && !writeGo |=> r.eng == ENG_IDLE && r.op == OP_IDLE
    && !r.notReady)
    else $error("calibration end did not return to idle");

  a_cal_end_pin: assert property (
    calDone && !writeGo && !csN ##1 !csN |-> !doutRdyOut)
    else $error("ready pin not low after calibration");

  a_scale_store: assert property (
    convDone && !writeGo |=> r.data == $past(scaled))
    else $error("data register missed scaled result");

  a_zero_route: assert property (
    r.eng == ENG_CAL && r.op == OP_ZERO_INT |-> inputSel == SEL_ZERO)
    else $error("zero reference not routed");

  a_cal_length: assert property (
    writeGo && r.awAddr == MODE_ADDR && next_r.eng == ENG_CAL
    |=> r.periodsLeft == $past(calP) && r.periodCnt == '0)
    else $error("calibration length wrong");

  a_period_bound: assert property (
    r.eng != ENG_IDLE |-> r.periodCnt < periodLen)
    else $error("period counter overran");

  a_word_legal: assert property (
    r.filterWord != '0)
    else $error("filter word is zero");

  a_chan_restart: assert property (
    writeGo && r.awAddr == CONF_ADDR && r.eng == ENG_CONV
    && next_r.tempSel != r.tempSel
    |=> r.modReset && r.periodsLeft == $past(settleP))
    else $error("channel change did not restart filter");

  a_temp_route: assert property (
    r.eng == ENG_CONV && r.tempSel |-> inputSel == SEL_TEMP)
    else $error("temperature sensor not routed");

  a_zl_reload: assert property (
    convDone && r.zeroLatency && !writeGo
    && r.op == OP_CONT |=> r.periodsLeft == $past(settleP))
    else $error("zero latency period wrong");

endmodule // acfc_control

// ### acfc_conv_model.sv
`timescale 1ns/1ps
module acfc_conv_model
  import acfc_pkg::*;
#(
  parameter logic [23:0] ZERO_REF  = 24'h000240,
  parameter logic [23:0] FULL_REF  = 24'h7ff000,
  parameter logic [23:0] TEMP_CODE = 24'h8ccc56
) (
  // Selection from the block
  input  wire acfc_sel_t   inputSel,
  // Voltage at the external pins
  input  wire logic [23:0] extVal,
  // Result of the modulator
  output logic [23:0]      rawSample
);
  // ----------------------------------------------------------------
  // Input multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    case (inputSel)
      SEL_ZERO: rawSample = ZERO_REF;
      SEL_FULL: rawSample = FULL_REF;
      SEL_TEMP: rawSample = TEMP_CODE;
      default:  rawSample = extVal;
    endcase
  end
endmodule // acfc_conv_model

// ### tb.sv
`timescale 1ns/1ps
module tb;
  import acfc_pkg::*;
  localparam int          P  = 16;
  localparam logic [23:0] ZR = 24'h000240;
  localparam logic [23:0] FR = 24'h7ff000;
  localparam logic [23:0] TC = 24'h8ccc56;
  logic          clk;
  logic          nrst;
  logic          csN;
  acfc_axi_in_t  ax;
  acfc_axi_out_t ao;
  acfc_sel_t     inputSel;
  logic          modReset;
  logic          doutRdyOut;
  logic          doutRdyOeN;
  logic [23:0]   rawSample;
  logic [23:0]   extVal;
  logic [33:0]   expQ[$];
  int            error_cnt;
  int            compares;
  int            cyc;
  int            n;
  int            mrCnt;
  logic [33:0]   expNote;
  logic [23:0]   x0;
  logic [23:0]   r;
  logic [23:0]   v;
  time           t0;

  acfc_control #(.PERIOD_MULT(1)) DUT (.clk(clk), .nrst(nrst),
    .axiIn(ax), .axiOut(ao), .rawSample(rawSample),
    .inputSel(inputSel), .modReset(modReset), .csN(csN),
    .doutRdyOut(doutRdyOut), .doutRdyOeN(doutRdyOeN));
  acfc_conv_model #(.ZERO_REF(ZR), .FULL_REF(FR), .TEMP_CODE(TC)) conv (
    .inputSel(inputSel), .extVal(extVal), .rawSample(rawSample));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [23:0] scale(input logic [23:0] raw,
      input logic [23:0] off, input logic [23:0] fs);
    logic signed [49:0] p;
    p = ($signed({26'h0, raw}) - $signed({26'h0, off}))
        * $signed({26'h0, fs});
    p = (p >>> 23) + 50'sh800000;
    if (p < 0) return 24'h0;
    if (p > 50'shffffff) return 24'hffffff;
    return p[23:0];
  endfunction

  function automatic logic [31:0] mw(input logic [2:0] op,
      input logic ch, input logic th, input logic zl);
    return {8'h0, op, 7'h0, ch, th, zl, 1'b0, 10'h010};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, tb_;
    @(posedge clk);
    ax.awvalid <= 1'b1;
    ax.awaddr  <= a;
    ax.wvalid  <= 1'b1;
    ax.wdata   <= d;
    ax.wstrb   <= 4'hf;
    ax.bready  <= 1'b1;
    tb_ = 1'b0;
    while (!tb_) begin
      @(negedge clk);
      ta = ao.awready;
      tw = ao.wready;
      tb_ = ao.bvalid;
      if (tb_) chk({32'h0, ao.bresp}, {32'h0, er});
      @(posedge clk);
      if (ta) ax.awvalid <= 1'b0;
      if (tw) ax.wvalid <= 1'b0;
      if (tb_) ax.bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic ta, tr;
    @(posedge clk);
    expQ.push_back({er, e});
    ax.arvalid <= 1'b1;
    ax.araddr  <= a;
    ax.rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = ao.arready;
      tr = ao.rvalid;
      @(posedge clk);
      if (ta) ax.arvalid <= 1'b0;
      if (tr) ax.rready <= 1'b0;
    end
  endtask

  task automatic waitrdy(output int k);
    k = 0;
    @(negedge clk);
    while (doutRdyOut !== 1'b0) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
  endtask

  task automatic cal(input logic [31:0] m, input logic [31:0] c,
                     input int k, input acfc_sel_t s);
    int nn;
    wr(CONF_ADDR, c, RESP_OKAY);
    wr(MODE_ADDR, m, RESP_OKAY);
    @(negedge clk);
    chk({32'h0, doutRdyOut, doutRdyOeN}, 34'h2);
    chk({32'h0, inputSel}, {32'h0, s});
    waitrdy(nn);
    chk({33'h0, (nn >= k*P-4 && nn <= k*P+4)}, 34'h1);
    rd(STAT_ADDR, 32'h0, RESP_OKAY);
    rd(MODE_ADDR, {m[31:24], 3'h2, m[20:0]}, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // Read checker and timeout
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (ao.rvalid === 1'b1 && ax.rready === 1'b1 && expQ.size() > 0) begin
      expNote = expQ.pop_front();
      if (expNote[33:32] == RESP_SLVERR) begin
        chk({ao.rresp, 32'h0}, {expNote[33:32], 32'h0});
      end else begin
        chk({ao.rresp, ao.rdata}, expNote);
      end
    end
    if (modReset === 1'b1) begin
      mrCnt++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ax = '0;
    nrst = 1'b0;
    csN = 1'b1;
    extVal = 24'h0;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    mrCnt = 0;
    void'($urandom(32'h3b67));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({32'h0, doutRdyOut, doutRdyOeN}, 34'h3);
    @(posedge clk);
    csN <= 1'b0;
    rd(MODE_ADDR, 32'h00400060, RESP_OKAY);
    rd(CONF_ADDR, 32'h0, RESP_OKAY);
    rd(STAT_ADDR, 32'h80, RESP_OKAY);
    rd(OFFC_ADDR, 32'h00800000, RESP_OKAY);
    rd(FSC_ADDR, 32'h00800000, RESP_OKAY);
    rd(8'h18, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h1, RESP_SLVERR);
    $display("test reset done");
    cal(mw(3'h4, 1, 0, 0), 0, 2, SEL_ZERO);
    cal(mw(3'h4, 0, 1, 0), 0, 3, SEL_ZERO);
    cal(mw(3'h4, 0, 0, 0), 0, 4, SEL_ZERO);
    cal(mw(3'h5, 0, 0, 0), 0, 4, SEL_FULL);
    cal(mw(3'h5, 0, 0, 0), 1, 8, SEL_FULL);
    rd(OFFC_ADDR, {8'h0, ZR}, RESP_OKAY);
    rd(FSC_ADDR, {8'h0, FR - ZR}, RESP_OKAY);
    $display("test internal calibration done");
    x0 = 24'($urandom_range(32'h100000, 32'h1000));
    extVal <= x0;
    cal(mw(3'h6, 0, 0, 0), 0, 4, SEL_EXT);
    extVal <= x0 + 24'h400000;
    cal(mw(3'h7, 0, 0, 0), 0, 4, SEL_EXT);
    rd(OFFC_ADDR, {8'h0, x0}, RESP_OKAY);
    rd(FSC_ADDR, 32'h00400000, RESP_OKAY);
    $display("test system calibration done");
    r = 24'($urandom);
    extVal <= r;
    rd(DATA_ADDR, 32'h0, RESP_OKAY);
    wr(MODE_ADDR, mw(3'h0, 0, 0, 0), RESP_OKAY);
    waitrdy(n);
    chk({33'h0, (n >= 4*P-4 && n <= 4*P+4)}, 34'h1);
    t0 = $time;
    rd(DATA_ADDR, {8'h0, scale(r, x0, 24'h400000)}, RESP_OKAY);
    waitrdy(n);
    chk({33'h0, (($time - t0) / 20) inside {[P-2:P+2]}}, 34'h1);
    wr(OFFC_ADDR, $urandom, RESP_OKAY);
    rd(OFFC_ADDR, {8'h0, x0}, RESP_OKAY);
    $display("test conversion done");
    wr(MODE_ADDR, mw(3'h0, 0, 0, 1), RESP_OKAY);
    waitrdy(n);
    t0 = $time;
    rd(DATA_ADDR, {8'h0, scale(r, x0, 24'h400000)}, RESP_OKAY);
    waitrdy(n);
    chk({33'h0, (($time - t0) / 20) inside {[4*P-2:4*P+2]}}, 34'h1);
    rd(DATA_ADDR, {8'h0, scale(r, x0, 24'h400000)}, RESP_OKAY);
    wr(CONF_ADDR, 32'h8, RESP_OKAY);
    @(negedge clk);
    chk({32'h0, inputSel}, {32'h0, SEL_TEMP});
    waitrdy(n);
    rd(DATA_ADDR, {8'h0, scale(TC, x0, 24'h400000)}, RESP_OKAY);
    $display("test zero latency and sensor done");
    wr(MODE_ADDR, mw(3'h1, 0, 0, 0), RESP_OKAY);
    waitrdy(n);
    rd(MODE_ADDR, mw(3'h2, 0, 0, 0), RESP_OKAY);
    v = 24'($urandom);
    wr(MODE_ADDR, mw(3'h2, 0, 0, 0), RESP_OKAY);
    wr(OFFC_ADDR, {8'h0, v}, RESP_OKAY);
    rd(OFFC_ADDR, {8'h0, v}, RESP_OKAY);
    wr(MODE_ADDR, mw(3'h3, 0, 0, 0), RESP_OKAY);
    wr(FSC_ADDR, {8'h0, v}, RESP_OKAY);
    rd(FSC_ADDR, {8'h0, v}, RESP_OKAY);
    wr(MODE_ADDR, 32'h00400000, RESP_OKAY);
    rd(MODE_ADDR, 32'h00400001, RESP_OKAY);
    repeat (3) @(posedge clk);
    chk(34'(mrCnt), 34'he);
    $display("test coefficient write done");
    end_of_test();
  end
endmodule // tb
